// ===== pkg/buffer_status_consts.svh
`ifndef BUFFER_STATUS_CONSTS_SVH
`define BUFFER_STATUS_CONSTS_SVH

// register byte addresses
`define CONTROL_ADDR 32'h0001_0680
`define STATUS_ADDR 32'h0001_0690
`define IRQ_ENABLE_ADDR 32'h0001_0694
`define PW_ENABLE_ADDR 32'h0001_0698

// reset values
`define STATUS_RESET 32'h0001_8000
`define ENABLE_RESET 32'h0000_0000

// sticky flag bits that software may clear (bit 0 of the map is bit 31 here)
`define STATUS_FLAG_MASK 32'hFFC0_19FB

// vector positions of the flags
`define IN_PAYLOAD_COR_BIT 5'h1F
`define IN_PAYLOAD_FAT_BIT 5'h1E
`define IN_LABEL_COR_BIT 5'h1D
`define IN_LABEL_FAT_BIT 5'h1C
`define IN_LFL_COR_BIT 5'h1B
`define IN_LFL_FAT_BIT 5'h1A
`define IN_OVH_COR_BIT 5'h19
`define IN_OVH_FAT_BIT 5'h18
`define IN_NODE_COR_BIT 5'h17
`define IN_NODE_FAT_BIT 5'h16
`define IN_VACANT_BIT 5'h10
`define OUT_VACANT_BIT 5'h0F
`define OUT_PAYLOAD_COR_BIT 5'h0C
`define OUT_PAYLOAD_FAT_BIT 5'h0B
`define OUT_OVH_COR_BIT 5'h08
`define OUT_OVH_FAT_BIT 5'h07
`define OUT_NODE_COR_BIT 5'h06
`define OUT_NODE_FAT_BIT 5'h05
`define OUT_STORAGE_BIT 5'h04
`define OUT_QUEUE_FULL_BIT 5'h03
`define OUT_UNUSED_LANE_BIT 5'h01
`define OUT_OVERSIZE_BIT 5'h00
`define HOLD_FLOWS_BIT 5'h10

// ingress fatal flags gathered for the discard or hold reaction
`define IN_FATAL_MASK 32'h5540_0000

// longest legal packet on the egress enqueue interface, in bytes
`define MAX_PACKET_BYTES 9'h114

`endif

// ===== pkg/buffer_status_pkg.sv
package buffer_status_pkg;

    // one memory read as seen by the error-correcting check
    typedef struct packed {
        logic valid;
        logic parity_bad;
        logic [7:0] syndrome;
    } ecc_check_type;

    // one enqueue request toward the egress manager
    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic [15:0] length;
        logic storage_ok;
        logic queue_ok;
    } enqueue_type;

    // path lane configuration
    typedef struct packed {
        logic [4:0] channels;
        logic single_lane_ports;
    } lane_config_type;

    // whole register state of the block
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] irq_enable;
        logic [31:0] pw_enable;
        logic hold_flows;
        logic [31:0] rdata;
        logic irq;
        logic pw;
        logic discard_all;
        logic backpressure_all;
    } state_type;

endpackage

// ===== design/packet_buffer_error_status.sv
`timescale 1ns/1ns
`include "buffer_status_consts.svh"
// Functional notes
// - one-bit faults correctable, two-bit faults fatal
// - ingress payload flags at bits 0,1
// - ingress label flags at bits 2,3
// - ingress label free list at bits 4,5
// - ingress overhead memory at bits 6,7
// - ingress node free list at bits 8,9
// - corrected flags only with protection on
// - bit 15 live ingress empty, reads 1
// - bit 16 live egress empty, reads 1
// - empty bits never reach interrupt summary
// - egress payload flags at bits 19,20
// - egress overhead memory at bits 23,24
// - egress node free list at bits 25,26
// - bit 27 on no payload storage
// - bit 28 on no request queue entry
// - bit 30 on enqueue to unused channel
// - bad-channel check watches channels 1 to n-1, never channel 0
// - no bad-channel check in single-lane ports
// - bit 31 on packet over 276 bytes
// - flags sticky until software writes one
// - one event may raise both summaries
// - summaries gated by the enable registers
// - ingress fatal discards inbound packets by default
// - hold control turns fatal into full backpressure
module packet_buffer_error_status #(
    parameter int CHANNELS = 16
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory checks: 0-4 ingress payload/label/label list/overhead/node list, 5-7 egress payload/overhead/node list
    input wire buffer_status_pkg::ecc_check_type [7:0] mem_check,
    input wire logic ecc_on,
    // egress enqueue interface and path setup
    input wire buffer_status_pkg::enqueue_type enqueue,
    input wire buffer_status_pkg::lane_config_type lane_config,
    // live occupancy
    input wire logic in_queue_vacant,
    input wire logic out_queue_vacant,
    // notifications and ingress reaction
    output logic buffer_irq_summary,
    output logic buffer_portwrite_summary,
    output logic in_discard_all,
    output logic in_backpressure_all
);
    import buffer_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // flag positions of the protected memories, index as on mem_check
    localparam logic [7:0][4:0] COR_POS = {`OUT_NODE_COR_BIT, `OUT_OVH_COR_BIT,
        `OUT_PAYLOAD_COR_BIT, `IN_NODE_COR_BIT, `IN_OVH_COR_BIT, `IN_LFL_COR_BIT,
        `IN_LABEL_COR_BIT, `IN_PAYLOAD_COR_BIT};
    localparam logic [7:0][4:0] FAT_POS = {`OUT_NODE_FAT_BIT, `OUT_OVH_FAT_BIT,
        `OUT_PAYLOAD_FAT_BIT, `IN_NODE_FAT_BIT, `IN_OVH_FAT_BIT, `IN_LFL_FAT_BIT,
        `IN_LABEL_FAT_BIT, `IN_PAYLOAD_FAT_BIT};

    state_type s;
    state_type next_s;
    logic [7:0] cor_ev;
    logic [7:0] fat_ev;
    logic [31:0] set_ev;
    logic [31:0] clr_ev;
    logic [31:0] lane_mask;
    logic [31:0] read_word;
    logic setup;
    logic access;
    logic mapped;
    logic bad_lane;

    ////////////////////////////////////////////////////////////////////////////
    // secded classification: overall parity wrong means one bit, correctable;
    // parity right with a nonzero syndrome means two bits, fatal
    for (genvar i = 0; i < 8; i++) begin : g_ecc
        assign cor_ev[i] = mem_check[i].valid & ecc_on & mem_check[i].parity_bad;
        // without correction any mismatch is fatal, as nothing can be repaired
        assign fat_ev[i] = mem_check[i].valid & (ecc_on
            ? (~mem_check[i].parity_bad & (|mem_check[i].syndrome))
            : (mem_check[i].parity_bad | (|mem_check[i].syndrome)));
    end

    // bad channel: only interfaces 1..n-1 are watched, and never in single-lane ports
    assign bad_lane = enqueue.valid & ~lane_config.single_lane_ports
        & (32'(enqueue.channel) < 32'(lane_config.channels))
        & (enqueue.channel != 4'h0);
    assign lane_mask = 32'(CHANNELS);

    ////////////////////////////////////////////////////////////////////////////
    // apb phases; zero wait states, read data captured in setup
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == `CONTROL_ADDR) | (paddr == `STATUS_ADDR)
        | (paddr == `IRQ_ENABLE_ADDR) | (paddr == `PW_ENABLE_ADDR);
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign prdata = s.rdata;

    // read mux; reserved bits read zero
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (paddr)
            `CONTROL_ADDR: read_word[`HOLD_FLOWS_BIT] = s.hold_flows;
            `STATUS_ADDR: begin
                read_word = s.flags & `STATUS_FLAG_MASK;
                read_word[`IN_VACANT_BIT] = in_queue_vacant;
                read_word[`OUT_VACANT_BIT] = out_queue_vacant;
            end
            `IRQ_ENABLE_ADDR: read_word = s.irq_enable;
            `PW_ENABLE_ADDR: read_word = s.pw_enable;
            default: read_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // events and write-one-to-clear strobes
    always_comb begin
        logic [31:0] wmask;
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        set_ev = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            set_ev[COR_POS[k]] = cor_ev[k];
            set_ev[FAT_POS[k]] = fat_ev[k];
        end
        set_ev[`OUT_STORAGE_BIT] = enqueue.valid & ~enqueue.storage_ok;
        set_ev[`OUT_QUEUE_FULL_BIT] = enqueue.valid & ~enqueue.queue_ok;
        set_ev[`OUT_UNUSED_LANE_BIT] = bad_lane & (lane_mask != 32'h0000_0000);
        set_ev[`OUT_OVERSIZE_BIT] = enqueue.valid
            & (enqueue.length > 16'(`MAX_PACKET_BYTES));
        clr_ev = 32'h0000_0000;
        if (access & pwrite & (paddr == `STATUS_ADDR)) begin
            clr_ev = pwdata & wmask & `STATUS_FLAG_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [31:0] wmask;
        logic [31:0] masked;
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        // reserved positions of the enable words never take a one
        masked = pwdata & `STATUS_FLAG_MASK;
        next_s = s;
        // a set in the same cycle as its clear wins, so no event is lost
        next_s.flags = ((s.flags & ~clr_ev) | set_ev) & `STATUS_FLAG_MASK;
        if (access & pwrite) begin
            if (paddr == `IRQ_ENABLE_ADDR) begin
                next_s.irq_enable = (s.irq_enable & ~wmask) | (masked & wmask);
            end
            if (paddr == `PW_ENABLE_ADDR) begin
                next_s.pw_enable = (s.pw_enable & ~wmask) | (masked & wmask);
            end
            if ((paddr == `CONTROL_ADDR) & pstrb[2]) begin
                next_s.hold_flows = pwdata[`HOLD_FLOWS_BIT];
            end
        end
        if (setup) begin
            next_s.rdata = read_word;
        end
        // summaries see only sticky flags, never the empty bits
        next_s.irq = |(s.flags & s.irq_enable & `STATUS_FLAG_MASK);
        next_s.pw = |(s.flags & s.pw_enable & `STATUS_FLAG_MASK);
        // reaction lasts while any ingress fatal flag stays set
        next_s.discard_all = (|(s.flags & `IN_FATAL_MASK)) & ~s.hold_flows;
        next_s.backpressure_all = (|(s.flags & `IN_FATAL_MASK)) & s.hold_flows;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.flags <= `STATUS_RESET & `STATUS_FLAG_MASK;
            s.irq_enable <= `ENABLE_RESET;
            s.pw_enable <= `ENABLE_RESET;
            s.hold_flows <= 1'b0;
            s.rdata <= 32'h0000_0000;
            s.irq <= 1'b0;
            s.pw <= 1'b0;
            s.discard_all <= 1'b0;
            s.backpressure_all <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // outputs come straight from flops, so the notification logic sees no glitches
    assign buffer_irq_summary = s.irq;
    assign buffer_portwrite_summary = s.pw;
    assign in_discard_all = s.discard_all;
    assign in_backpressure_all = s.backpressure_all;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a set in the same cycle as its clear must still land
    a_set_survives_clear: assert property (set_ev[`OUT_OVERSIZE_BIT] |=> s.flags[`OUT_OVERSIZE_BIT])
        else $error("oversize event lost");

    // a flag only drops through a written one
    a_flag_sticky: assert property (
        s.flags[`OUT_STORAGE_BIT] && !clr_ev[`OUT_STORAGE_BIT] |=> s.flags[`OUT_STORAGE_BIT])
        else $error("sticky flag dropped without a clear");

    // a clear with no competing event really empties the flag
    a_flag_cleared: assert property (
        clr_ev[`OUT_QUEUE_FULL_BIT] && !set_ev[`OUT_QUEUE_FULL_BIT] |=> !s.flags[`OUT_QUEUE_FULL_BIT])
        else $error("written one did not clear the flag");

    // with protection off a corrected flag can never rise
    a_cor_needs_ecc: assert property (
        !ecc_on |=> $stable(s.flags[`IN_LABEL_COR_BIT]) || !s.flags[`IN_LABEL_COR_BIT])
        else $error("corrected flag rose with protection off");

    // no corrected event is even formed while protection is off
    a_cor_blocked: assert property (!ecc_on |-> cor_ev == 8'h00)
        else $error("corrected event with protection off");

    // ingress payload two-bit fault lands in its fatal flag
    a_double_fatal: assert property (
        mem_check[0].valid && ecc_on && !mem_check[0].parity_bad
        && |mem_check[0].syndrome |=> s.flags[`IN_PAYLOAD_FAT_BIT])
        else $error("two-bit payload fault not flagged");

    // each protected memory reports into its own pair of flags
    for (genvar j = 0; j < 8; j++) begin : g_ecc_checks
        // overall parity wrong is a one-bit fault, repaired
        a_cor_lands: assert property (
            mem_check[j].valid && ecc_on && mem_check[j].parity_bad |=> s.flags[COR_POS[j]])
            else $error("corrected fault not flagged");

        // a repaired fault must never count as fatal
        a_single_not_fatal: assert property (
            mem_check[j].valid && ecc_on && mem_check[j].parity_bad |-> !fat_ev[j])
            else $error("one-bit fault treated as fatal");

        // good parity with a nonzero syndrome is a two-bit fault
        a_fat_lands: assert property (
            mem_check[j].valid && ecc_on && !mem_check[j].parity_bad && (|mem_check[j].syndrome)
            |=> s.flags[FAT_POS[j]])
            else $error("fatal fault not flagged");
    end

    // empty bits are taken live when the read is set up
    a_empty_live: assert property (
        setup && paddr == `STATUS_ADDR |=> prdata[`IN_VACANT_BIT] == $past(in_queue_vacant))
        else $error("ingress empty bit not live");

    // same for the egress half
    a_out_empty_live: assert property (
        setup && paddr == `STATUS_ADDR |=> prdata[`OUT_VACANT_BIT] == $past(out_queue_vacant))
        else $error("egress empty bit not live");

    // reserved status bits read zero whatever the flops hold
    a_reserved_zero: assert property (
        access && paddr == `STATUS_ADDR |-> (prdata & ~(`STATUS_FLAG_MASK
        | (32'h1 << `IN_VACANT_BIT) | (32'h1 << `OUT_VACANT_BIT))) == 32'h0000_0000)
        else $error("reserved status bit read nonzero");

    // reserved flag and enable positions can never hold a one
    a_reserved_flops: assert property (
        ((s.flags | s.irq_enable | s.pw_enable) & ~`STATUS_FLAG_MASK) == 32'h0000_0000)
        else $error("reserved flop bit set");

    // an unmapped read returns zero along with the error
    a_unmapped_zero: assert property (
        access && !mapped && !pwrite |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // a storage shortage on enqueue is flagged
    a_storage_flag: assert property (
        enqueue.valid && !enqueue.storage_ok |=> s.flags[`OUT_STORAGE_BIT])
        else $error("storage shortage not flagged");

    // a request queue shortage on enqueue is flagged
    a_queue_flag: assert property (
        enqueue.valid && !enqueue.queue_ok |=> s.flags[`OUT_QUEUE_FULL_BIT])
        else $error("request queue shortage not flagged");

    // one byte over the limit is already too long
    a_oversize_flag: assert property (
        enqueue.valid && enqueue.length > 16'(`MAX_PACKET_BYTES) |=> s.flags[`OUT_OVERSIZE_BIT])
        else $error("oversize packet not flagged");

    // exactly the limit is still legal
    a_length_legal: assert property (
        enqueue.valid && enqueue.length <= 16'(`MAX_PACKET_BYTES) |-> !set_ev[`OUT_OVERSIZE_BIT])
        else $error("legal packet flagged as oversize");

    // interfaces at or above the configured count are never watched
    a_lane_watch: assert property (
        32'(enqueue.channel) >= 32'(lane_config.channels) |-> !bad_lane)
        else $error("bad channel seen above the channel count");

    // a detected bad channel always reaches its flag
    a_lane_flag: assert property (
        bad_lane |=> s.flags[`OUT_UNUSED_LANE_BIT])
        else $error("unused channel enqueue not flagged");

    // single-lane ports cannot see the condition at all
    a_single_lane: assert property (lane_config.single_lane_ports |-> !bad_lane)
        else $error("bad channel seen in single-lane mode");

    // summaries follow the enabled flags one cycle later
    a_irq_gated: assert property (
        |(s.flags & s.irq_enable & `STATUS_FLAG_MASK) |=> buffer_irq_summary)
        else $error("enabled flag did not raise the summary");

    // nothing enabled, nothing raised, empty bits included
    a_irq_quiet: assert property (
        (s.flags & s.irq_enable) == 32'h0000_0000 |=> !buffer_irq_summary)
        else $error("summary raised without an enabled flag");

    // port-write summary follows its own enables
    a_pw_gated: assert property (
        |(s.flags & s.pw_enable) |=> buffer_portwrite_summary)
        else $error("enabled flag did not raise the port-write summary");

    // and stays low without an enabled flag
    a_pw_quiet: assert property (
        (s.flags & s.pw_enable) == 32'h0000_0000 |=> !buffer_portwrite_summary)
        else $error("port-write summary raised without an enabled flag");

    // one flag enabled on both sides drives both summaries together
    a_both_notify: assert property (
        |(s.flags & s.irq_enable & s.pw_enable) |=> buffer_irq_summary && buffer_portwrite_summary)
        else $error("shared event did not reach both summaries");

    // a full-word enable write lands masked to the flag positions
    a_enable_write: assert property (
        access && pwrite && paddr == `IRQ_ENABLE_ADDR && pstrb == 4'hF
        |=> s.irq_enable == ($past(pwdata) & `STATUS_FLAG_MASK))
        else $error("interrupt enable write lost");

    // the hold control is taken from its byte lane
    a_hold_write: assert property (
        access && pwrite && paddr == `CONTROL_ADDR && pstrb[2]
        |=> s.hold_flows == $past(pwdata[`HOLD_FLOWS_BIT]))
        else $error("hold control write lost");

    // a standing ingress label fatal flag always brings exactly one reaction
    a_fatal_reaction: assert property (
        s.flags[`IN_LABEL_FAT_BIT] ##1 s.flags[`IN_LABEL_FAT_BIT] |-> in_discard_all != in_backpressure_all)
        else $error("ingress fatal reaction missing");

    // by default an ingress fatal error discards, never holds
    a_discard_default: assert property (
        |(s.flags & `IN_FATAL_MASK) && !s.hold_flows |=> in_discard_all && !in_backpressure_all)
        else $error("fatal error did not discard inbound packets");

    // with the hold control set every flow is held instead
    a_hold_on_fatal: assert property (
        |(s.flags & `IN_FATAL_MASK) && s.hold_flows |=> in_backpressure_all && !in_discard_all)
        else $error("fatal error did not hold every flow");

    // with no ingress fatal flag set both reactions stay off
    a_no_reaction: assert property (
        (s.flags & `IN_FATAL_MASK) == 32'h0000_0000 |=> !in_discard_all && !in_backpressure_all)
        else $error("reaction active without a fatal flag");

    // main scenarios worth seeing at least once
    c_clear_flag: cover property (clr_ev[`OUT_QUEUE_FULL_BIT] && s.flags[`OUT_QUEUE_FULL_BIT]);
    c_both_notify: cover property (buffer_irq_summary && buffer_portwrite_summary);
    c_hold_flows: cover property (in_backpressure_all);
    c_set_and_clear: cover property (set_ev[`OUT_OVERSIZE_BIT] && clr_ev[`OUT_OVERSIZE_BIT]);
    c_bad_lane: cover property (bad_lane);
endmodule

// ===== test/tb_packet_buffer_error_status.sv
`timescale 1ns/1ns
`include "buffer_status_consts.svh"
module tb_packet_buffer_error_status;
    import buffer_status_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ecc_on, err;
    logic [31:0] paddr, pwdata, prdata, rdata, cm;
    logic [3:0] pstrb;
    ecc_check_type [7:0] mem_check;
    enqueue_type enqueue;
    lane_config_type lane_config;
    logic in_queue_vacant, out_queue_vacant, irq, pw, discard, hold_bp;
    logic [4:0] cor_bit [8];
    int n_fail, tests_run;
    localparam logic [31:0] V = `STATUS_RESET;

    packet_buffer_error_status #(.CHANNELS(16)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_check(mem_check), .ecc_on(ecc_on), .enqueue(enqueue),
        .lane_config(lane_config), .in_queue_vacant(in_queue_vacant),
        .out_queue_vacant(out_queue_vacant), .buffer_irq_summary(irq),
        .buffer_portwrite_summary(pw), .in_discard_all(discard), .in_backpressure_all(hold_bp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and shared tasks
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the bound on the access phase guards against a hung slave
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20) begin
            n_fail++;
            wrap_up();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask

    // registered outputs lag the flag by one edge; look after they have landed
    task settle;
        repeat (2) @(posedge pclk);
        #10;
    endtask

    task ev(input int m, input logic par, input logic [7:0] syn);
        @(posedge pclk);
        mem_check[m] <= {1'b1, par, syn};
        @(posedge pclk);
        mem_check[m] <= '0;
    endtask

    task enq(input logic [3:0] ch, input logic [15:0] len, input logic so, input logic qo, input logic [31:0] e);
        @(posedge pclk);
        enqueue <= {1'b1, ch, len, so, qo};
        @(posedge pclk);
        enqueue <= '0;
        rd(`STATUS_ADDR, V | e);
        apb(1'b1, `STATUS_ADDR, 32'hFFFF_FFFF);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        rd(`STATUS_ADDR, V);
        rd(`IRQ_ENABLE_ADDR, `ENABLE_RESET);
        rd(`PW_ENABLE_ADDR, `ENABLE_RESET);
        rd(32'h0001_0684, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        $display("reset test done");
    endtask

    // sticky check writes ones everywhere except the flag under test
    task t_ecc;
        for (int m = 0; m < 8; m++) begin
            ev(m, 1'b1, 8'h00);
            rd(`STATUS_ADDR, V | (32'h1 << cor_bit[m]));
            apb(1'b1, `STATUS_ADDR, ~(32'h1 << cor_bit[m]));
            rd(`STATUS_ADDR, V | (32'h1 << cor_bit[m]));
            apb(1'b1, `STATUS_ADDR, 32'h1 << cor_bit[m]);
            rd(`STATUS_ADDR, V);
            ev(m, 1'b0, 8'h5A);
            rd(`STATUS_ADDR, V | (32'h1 << (cor_bit[m] - 5'h01)));
            apb(1'b1, `STATUS_ADDR, 32'h1 << (cor_bit[m] - 5'h01));
        end
        ecc_on <= 1'b0;
        cm = 32'h0;
        for (int m = 0; m < 8; m++) begin
            ev(m, 1'b1, 8'h00);
            cm = cm | (32'h1 << cor_bit[m]);
        end
        apb(1'b0, `STATUS_ADDR, 32'h0);
        chk(rdata & cm, 32'h0);
        apb(1'b1, `STATUS_ADDR, 32'hFFFF_FFFF);
        ecc_on <= 1'b1;
        $display("ecc test done");
    endtask

    task t_enqueue;
        lane_config <= {5'd4, 1'b0};
        enq(4'd0, 16'd64, 1'b0, 1'b1, 32'h1 << `OUT_STORAGE_BIT);
        enq(4'd0, 16'd64, 1'b1, 1'b0, 32'h1 << `OUT_QUEUE_FULL_BIT);
        enq(4'd0, 16'd277, 1'b1, 1'b1, 32'h1 << `OUT_OVERSIZE_BIT);
        enq(4'd0, 16'd276, 1'b1, 1'b1, 32'h0);
        enq(4'd3, 16'd64, 1'b1, 1'b1, 32'h1 << `OUT_UNUSED_LANE_BIT);
        enq(4'd4, 16'd64, 1'b1, 1'b1, 32'h0);
        lane_config <= {5'd4, 1'b1};
        enq(4'd3, 16'd64, 1'b1, 1'b1, 32'h0);
        $display("enqueue test done");
    endtask

    task t_summary;
        in_queue_vacant <= 1'b0;
        rd(`STATUS_ADDR, 32'h0000_8000);
        out_queue_vacant <= 1'b0;
        in_queue_vacant <= 1'b1;
        rd(`STATUS_ADDR, 32'h0001_0000);
        apb(1'b1, `IRQ_ENABLE_ADDR, 32'hFFFF_FFFF);
        rd(`IRQ_ENABLE_ADDR, `STATUS_FLAG_MASK);
        settle();
        chk({31'h0, irq}, 32'h0);
        out_queue_vacant <= 1'b1;
        apb(1'b1, `IRQ_ENABLE_ADDR, 32'h1 << `OUT_OVERSIZE_BIT);
        enq(4'd0, 16'd300, 1'b1, 1'b1, 32'h1 << `OUT_OVERSIZE_BIT);
        ev(5, 1'b0, 8'h33);
        settle();
        // oversize was cleared inside enq, payload fatal is not enabled yet
        chk({30'h0, irq, pw}, 32'h0);
        apb(1'b1, `PW_ENABLE_ADDR, 32'h1 << `OUT_PAYLOAD_FAT_BIT);
        settle();
        chk({30'h0, irq, pw}, 32'h1);
        apb(1'b1, `IRQ_ENABLE_ADDR, 32'h1 << `OUT_PAYLOAD_FAT_BIT);
        settle();
        chk({30'h0, irq, pw}, 32'h3);
        apb(1'b1, `STATUS_ADDR, 32'hFFFF_FFFF);
        settle();
        chk({30'h0, irq, pw}, 32'h0);
        $display("summary test done");
    endtask

    task t_fatal;
        ev(1, 1'b0, 8'h11);
        settle();
        chk({30'h0, discard, hold_bp}, 32'h2);
        apb(1'b1, `CONTROL_ADDR, 32'h1 << `HOLD_FLOWS_BIT);
        settle();
        chk({30'h0, discard, hold_bp}, 32'h1);
        apb(1'b1, `STATUS_ADDR, 32'hFFFF_FFFF);
        settle();
        chk({30'h0, discard, hold_bp}, 32'h0);
        $display("fatal test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cor_bit = '{`IN_PAYLOAD_COR_BIT, `IN_LABEL_COR_BIT, `IN_LFL_COR_BIT, `IN_OVH_COR_BIT,
                    `IN_NODE_COR_BIT, `OUT_PAYLOAD_COR_BIT, `OUT_OVH_COR_BIT, `OUT_NODE_COR_BIT};
        n_fail = 0;
        tests_run = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        mem_check = '0;
        enqueue = '0;
        lane_config = {5'd4, 1'b0};
        ecc_on = 1'b1;
        in_queue_vacant = 1'b1;
        out_queue_vacant = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ecc();
        t_enqueue();
        t_summary();
        t_fatal();
        wrap_up();
    end
endmodule
